// File: hdl/fws_cycle.sv
// One asynchronous flash bus cycle, read or write, with registered pins
`timescale 1ns/1ps
module fws_cycle
(
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          nrst,
  // Request
  input  wire logic                          start,
  input  wire logic                          wr,
  input  wire logic [fws_pkg::FL_ADDR_W-1:0] addr,
  input  wire logic [fws_pkg::FL_DATA_W-1:0] wdata,
  // Answer
  output logic                               done,
  output logic [fws_pkg::FL_DATA_W-1:0]      rdata,
  // Flash side
  output fws_pkg::fws_pins_s                 pins,
  input  wire logic [fws_pkg::FL_DATA_W-1:0] dq_i
);

  // ==========================================================================
  // Phases
  // ==========================================================================
  typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD} fws_phase_e;

  localparam fws_pkg::fws_pins_s PINS_IDLE = '{addr: '0, dq_o: '0, dq_oe_n: 1'b1,
                                              ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};

  fws_phase_e                    ph_q,    ph_d;
  logic [7:0]                    cnt_q,   cnt_d;
  logic                          wr_q,    wr_d;
  logic                          done_q,  done_d;
  logic [fws_pkg::FL_DATA_W-1:0] rdata_q, rdata_d;
  fws_pkg::fws_pins_s            pins_q,  pins_d;

  always_comb
  begin
    ph_d    = ph_q;
    cnt_d   = cnt_q;
    wr_d    = wr_q;
    done_d  = 1'b0;
    rdata_d = rdata_q;
    pins_d  = pins_q;
    unique case (ph_q)
      PH_IDLE:
        if (start)
        begin
          wr_d           = wr;
          pins_d.addr    = addr;
          pins_d.dq_o    = wdata;
          pins_d.dq_oe_n = ~wr;
          pins_d.ce_n    = 1'b0;
          pins_d.oe_n    = 1'b1;
          pins_d.we_n    = 1'b1;
          ph_d           = PH_SETUP;
        end
      PH_SETUP:
      begin
        // Write only with chip select low, write strobe low, output enable high
        pins_d.we_n = ~wr_q;
        pins_d.oe_n = wr_q;
        cnt_d       = wr_q ? 8'(fws_pkg::WE_PULSE_CYC) : 8'(fws_pkg::READ_ACC_CYC);
        ph_d        = PH_STROBE;
      end
      PH_STROBE:
        if (cnt_q > 8'h01)
          cnt_d = cnt_q - 8'h01;
        else
        begin
          // Rising strobe closes the cycle; device status flips per read here
          if (!wr_q)
            rdata_d = dq_i;
          pins_d.we_n = 1'b1;
          pins_d.oe_n = 1'b1;
          pins_d.ce_n = 1'b1;
          cnt_d       = 8'(fws_pkg::RECOVER_CYC);
          ph_d        = PH_HOLD;
        end
      PH_HOLD:
        if (cnt_q > 8'h01)
          cnt_d = cnt_q - 8'h01;
        else
        begin
          // Data held past the strobe edge, released only now
          pins_d.dq_oe_n = 1'b1;
          done_d         = 1'b1;
          ph_d           = PH_IDLE;
        end
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ph_q    <= PH_IDLE;
      cnt_q   <= 8'h00;
      wr_q    <= 1'b0;
      done_q  <= 1'b0;
      rdata_q <= 8'h00;
      pins_q  <= PINS_IDLE;
    end
    else
    begin
      ph_q    <= ph_d;
      cnt_q   <= cnt_d;
      wr_q    <= wr_d;
      done_q  <= done_d;
      rdata_q <= rdata_d;
      pins_q  <= pins_d;
    end
  end

  assign done  = done_q;
  assign rdata = rdata_q;
  assign pins  = pins_q;

endmodule

// File: hdl/fws_flash_host.sv
// Host controller for NOR flash program/erase with status polling over APB
`timescale 1ns/1ps
module fws_flash_host
(
  // Clock and reset
  input  wire logic                               CORE_CLK,
  input  wire logic                               NRST,
  // APB slave
  input  wire logic                               PSEL,
  input  wire logic                               PENABLE,
  input  wire logic                               PWRITE,
  input  wire logic [fws_pkg::APB_AW-1:0]         PADDR,
  input  wire logic [31:0]                        PWDATA,
  output logic [31:0]                             PRDATA,
  output logic                                    PREADY,
  output logic                                    PSLVERR,
  // Flash pins
  output fws_pkg::fws_pins_s                      FL_PINS,
  input  wire logic [fws_pkg::FL_DATA_W-1:0]      FL_DQ_I,
  input  wire logic                               READY_BUSY_OUT,
  input  wire logic                               SUPPLY_LOCKOUT_LEVEL
);

  // ==========================================================================
  // Command sequences
  // ==========================================================================
  function automatic fws_pkg::fws_step_s seq_step(input fws_pkg::fws_op_e op,
                                                  input logic [2:0] idx,
                                                  input logic [fws_pkg::FL_ADDR_W-1:0] a,
                                                  input logic [fws_pkg::FL_DATA_W-1:0] d);
    fws_pkg::fws_step_s s;
    s = '{addr: fws_pkg::UNLOCK_A1, data: fws_pkg::UNLOCK_D1, last: 1'b0};
    // Second step of every unlock pair (index 1 and 4) goes to the second unlock address
    if (idx == 3'd1 || idx == 3'd4)
    begin
      s.addr = fws_pkg::UNLOCK_A2;
      s.data = fws_pkg::UNLOCK_D2;
    end
    unique case (op)
      fws_pkg::OP_PROG:
        if (idx == 3'd2)
          s.data = fws_pkg::CMD_PROG;
        else if (idx == 3'd3)
          s = '{addr: a, data: d, last: 1'b1};
      fws_pkg::OP_CHIP, fws_pkg::OP_SECTOR:
        if (idx == 3'd2)
          s.data = fws_pkg::CMD_ERASE;
        else if (idx == 3'd5)
        begin
          s.last = 1'b1;
          if (op == fws_pkg::OP_CHIP)
            s.data = fws_pkg::CMD_CHIP;
          else
            s = '{addr: a, data: fws_pkg::CMD_SECT, last: 1'b1};
        end
      fws_pkg::OP_ADDSEC:
        s = '{addr: a, data: fws_pkg::CMD_SECT, last: 1'b1};
      default:
        s = '{addr: a, data: fws_pkg::CMD_RESET, last: 1'b1};
    endcase
    return s;
  endfunction

  // ==========================================================================
  // APB decode
  // ==========================================================================
  logic        pready_q,  pready_d;
  logic [31:0] prdata_q,  prdata_d;
  logic        pslverr_q, pslverr_d;
  logic        acc_wr;
  logic        mapped;
  logic [7:0]  status_rd;

  // Access completes at the edge where PREADY is sampled high
  assign acc_wr = PSEL & PENABLE & pready_q & PWRITE;
  assign mapped = (PADDR == fws_pkg::REG_CTRL) || (PADDR == fws_pkg::REG_ADDR) ||
                  (PADDR == fws_pkg::REG_WDATA) || (PADDR == fws_pkg::REG_STATUS) ||
                  (PADDR == fws_pkg::REG_RDATA);

  // ==========================================================================
  // Sequencer state
  // ==========================================================================
  typedef enum logic [2:0] {
    S_IDLE, S_WRITE, S_PRE, S_POST, S_POLL_A, S_POLL_B, S_READ
  } fws_state_e;

  fws_state_e                    st_q,      st_d;
  fws_pkg::fws_op_e              op_q,      op_d;
  logic [2:0]                    idx_q,     idx_d;
  logic                          issued_q,  issued_d;
  logic                          recheck_q, recheck_d;
  logic                          failing_q, failing_d;
  logic [fws_pkg::FL_ADDR_W-1:0] addr_q,    addr_d;
  logic [fws_pkg::FL_DATA_W-1:0] wdata_q,   wdata_d;
  logic [fws_pkg::FL_DATA_W-1:0] first_q,   first_d;
  logic [fws_pkg::FL_DATA_W-1:0] rdata_q,   rdata_d;
  logic [fws_pkg::ST_W-1:0]      flags_q,   flags_d;

  fws_pkg::fws_step_s            step;
  logic                          cyc_start;
  logic                          cyc_wr;
  logic [fws_pkg::FL_ADDR_W-1:0] cyc_addr;
  logic                          cyc_done;
  logic [fws_pkg::FL_DATA_W-1:0] cyc_rdata;
  logic                          go;
  fws_pkg::fws_op_e              new_op;

  assign go     = acc_wr && (PADDR == fws_pkg::REG_CTRL);
  assign new_op = fws_pkg::fws_op_e'(PWDATA[2:0]);

  always_comb
  begin
    st_d      = st_q;
    op_d      = op_q;
    idx_d     = idx_q;
    issued_d  = issued_q;
    recheck_d = recheck_q;
    failing_d = failing_q;
    addr_d    = addr_q;
    wdata_d   = wdata_q;
    first_d   = first_q;
    rdata_d   = rdata_q;
    flags_d   = flags_q;
    step      = seq_step(op_q, idx_q, addr_q, wdata_q);
    cyc_start = 1'b0;
    cyc_wr    = 1'b0;
    cyc_addr  = addr_q;
    // Clears first so that a hardware set in the same cycle wins
    if (acc_wr && PADDR == fws_pkg::REG_STATUS)
      flags_d = flags_q & ~(PWDATA[fws_pkg::ST_W-1:0] & fws_pkg::STICKY_MASK);
    flags_d[fws_pkg::ST_RYBY]    = READY_BUSY_OUT;
    flags_d[fws_pkg::ST_LOCKOUT] = SUPPLY_LOCKOUT_LEVEL;
    if (acc_wr && PADDR == fws_pkg::REG_ADDR && st_q == S_IDLE)
      addr_d = PWDATA[fws_pkg::FL_ADDR_W-1:0];
    if (acc_wr && PADDR == fws_pkg::REG_WDATA && st_q == S_IDLE)
      wdata_d = PWDATA[fws_pkg::FL_DATA_W-1:0];
    if (st_q != S_IDLE && st_q != S_WRITE)
      cyc_start = ~issued_q;
    unique case (st_q)
      S_IDLE:
        if (go)
        begin
          // No point driving writes the device ignores below lockout
          if (SUPPLY_LOCKOUT_LEVEL || new_op == fws_pkg::OP_NONE || new_op > fws_pkg::OP_RESET)
            flags_d[fws_pkg::ST_REFUSED] = 1'b1;
          else
          begin
            op_d                      = new_op;
            idx_d                     = 3'd0;
            recheck_d                 = 1'b0;
            failing_d                 = 1'b0;
            flags_d[fws_pkg::ST_BUSY] = 1'b1;
            if (new_op == fws_pkg::OP_READ)
              st_d = S_READ;
            else if (new_op == fws_pkg::OP_ADDSEC)
              st_d = S_PRE;
            else
              st_d = S_WRITE;
          end
        end
      S_WRITE:
      begin
        cyc_start = ~issued_q;
        cyc_wr    = 1'b1;
        cyc_addr  = step.addr;
        if (cyc_done)
        begin
          idx_d = idx_q + 3'd1;
          // Whole unlock sequence goes out before any status is trusted
          if (step.last)
          begin
            if (op_q == fws_pkg::OP_ADDSEC)
              st_d = S_POST;
            else if (op_q == fws_pkg::OP_RESET)
              st_d = S_IDLE;
            else
              st_d = S_POLL_A;
          end
        end
      end
      S_PRE:
        if (cyc_done)
        begin
          flags_d[fws_pkg::ST_EWIN] = cyc_rdata[fws_pkg::BIT_EWIN];
          if (cyc_rdata[fws_pkg::BIT_EWIN])
          begin
            // Erase already running: the extra sector would be ignored
            flags_d[fws_pkg::ST_DROPPED] = 1'b1;
            st_d                         = S_IDLE;
          end
          else
            st_d = S_WRITE;
        end
      S_POST:
        if (cyc_done)
        begin
          flags_d[fws_pkg::ST_EWIN] = cyc_rdata[fws_pkg::BIT_EWIN];
          if (cyc_rdata[fws_pkg::BIT_EWIN])
            flags_d[fws_pkg::ST_DROPPED] = 1'b1;
          st_d = S_IDLE;
        end
      S_POLL_A:
        if (cyc_done)
        begin
          first_d = cyc_rdata;
          st_d    = S_POLL_B;
        end
      S_POLL_B:
        if (cyc_done)
        begin
          if (op_q == fws_pkg::OP_SECTOR)
            flags_d[fws_pkg::ST_EWIN] = cyc_rdata[fws_pkg::BIT_EWIN];
          if (cyc_rdata[fws_pkg::BIT_TOG1] == first_q[fws_pkg::BIT_TOG1])
            st_d = S_READ;
          else if (op_q == fws_pkg::OP_SECTOR && !cyc_rdata[fws_pkg::BIT_EWIN])
            // Accepted with window open: hand back so sectors can be added
            st_d = S_IDLE;
          else if (recheck_q)
          begin
            // Still toggling after the limit bit was seen: abort with reset
            failing_d = 1'b1;
            op_d      = fws_pkg::OP_RESET;
            idx_d     = 3'd0;
            st_d      = S_WRITE;
          end
          else
          begin
            // Limit bit only trusted while toggling continues
            recheck_d = cyc_rdata[fws_pkg::BIT_LIMIT];
            st_d      = S_POLL_A;
          end
        end
      S_READ:
        if (cyc_done)
        begin
          rdata_d = cyc_rdata;
          st_d    = S_IDLE;
        end
    endcase
    if (cyc_start)
      issued_d = 1'b1;
    if (cyc_done)
      issued_d = 1'b0;
    if (st_q != S_IDLE && st_d == S_IDLE)
    begin
      flags_d[fws_pkg::ST_BUSY] = 1'b0;
      flags_d[fws_pkg::ST_DONE] = 1'b1;
      if (failing_q)
        flags_d[fws_pkg::ST_FAIL] = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st_q      <= S_IDLE;
      op_q      <= fws_pkg::OP_NONE;
      idx_q     <= 3'd0;
      issued_q  <= 1'b0;
      recheck_q <= 1'b0;
      failing_q <= 1'b0;
      addr_q    <= '0;
      wdata_q   <= '0;
      first_q   <= '0;
      rdata_q   <= '0;
      flags_q   <= '0;
    end
    else
    begin
      st_q      <= st_d;
      op_q      <= op_d;
      idx_q     <= idx_d;
      issued_q  <= issued_d;
      recheck_q <= recheck_d;
      failing_q <= failing_d;
      addr_q    <= addr_d;
      wdata_q   <= wdata_d;
      first_q   <= first_d;
      rdata_q   <= rdata_d;
      flags_q   <= flags_d;
    end
  end

  // ==========================================================================
  // Bus cycle engine
  // ==========================================================================
  fws_cycle u_cycle
  (
    .clk   (CORE_CLK),
    .nrst  (NRST),
    .start (cyc_start),
    .wr    (cyc_wr),
    .addr  (cyc_addr),
    .wdata (step.data),
    .done  (cyc_done),
    .rdata (cyc_rdata),
    .pins  (FL_PINS),
    .dq_i  (FL_DQ_I)
  );

  // ==========================================================================
  // APB answer, one wait state on every access
  // ==========================================================================
  assign status_rd = flags_q;

  always_comb
  begin
    pready_d  = PSEL & PENABLE & ~pready_q;
    pslverr_d = pready_d & ~mapped;
    prdata_d  = prdata_q;
    if (pready_d)
    begin
      prdata_d = 32'h0000_0000;
      unique case (PADDR)
        fws_pkg::REG_CTRL:   prdata_d = {29'h0, op_q};
        fws_pkg::REG_ADDR:   prdata_d = {12'h000, addr_q};
        fws_pkg::REG_WDATA:  prdata_d = {24'h00_0000, wdata_q};
        fws_pkg::REG_STATUS: prdata_d = {24'h00_0000, status_rd};
        fws_pkg::REG_RDATA:  prdata_d = {24'h00_0000, rdata_q};
        default:             prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= pready_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign PREADY  = pready_q;
  assign PRDATA  = prdata_q;
  assign PSLVERR = pslverr_q;

endmodule

// File: hdl/fws_pkg.sv
// Constants, types and register map of the flash status and protection host controller
package fws_pkg;

  // ==========================================================================
  // Clock and bus timing
  // ==========================================================================
  localparam int CLK_PS        = 5000;
  localparam int T_WE_PULSE_NS = 50;
  localparam int T_READ_ACC_NS = 90;
  localparam int T_RECOVER_NS  = 20;

  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int WE_PULSE_CYC = ns_to_cyc(T_WE_PULSE_NS);
  localparam int READ_ACC_CYC = ns_to_cyc(T_READ_ACC_NS);
  localparam int RECOVER_CYC  = ns_to_cyc(T_RECOVER_NS);

  // ==========================================================================
  // Flash pin layout
  // ==========================================================================
  localparam int FL_ADDR_W = 20;
  localparam int FL_DATA_W = 8;
  localparam int BIT_POLL  = 7;
  localparam int BIT_TOG1  = 6;
  localparam int BIT_LIMIT = 5;
  localparam int BIT_EWIN  = 3;
  localparam int BIT_TOG2  = 2;

  typedef struct packed {
    logic [FL_ADDR_W-1:0] addr;
    logic [FL_DATA_W-1:0] dq_o;
    logic                 dq_oe_n;
    logic                 ce_n;
    logic                 oe_n;
    logic                 we_n;
  } fws_pins_s;

  typedef struct packed {
    logic [FL_ADDR_W-1:0] addr;
    logic [FL_DATA_W-1:0] data;
    logic                 last;
  } fws_step_s;

  // ==========================================================================
  // Flash command cycles (word addressing)
  // ==========================================================================
  localparam logic [FL_ADDR_W-1:0] UNLOCK_A1 = 20'h00555;
  localparam logic [FL_ADDR_W-1:0] UNLOCK_A2 = 20'h002aa;
  localparam logic [FL_DATA_W-1:0] UNLOCK_D1 = 8'haa;
  localparam logic [FL_DATA_W-1:0] UNLOCK_D2 = 8'h55;
  localparam logic [FL_DATA_W-1:0] CMD_PROG  = 8'ha0;
  localparam logic [FL_DATA_W-1:0] CMD_ERASE = 8'h80;
  localparam logic [FL_DATA_W-1:0] CMD_CHIP  = 8'h10;
  localparam logic [FL_DATA_W-1:0] CMD_SECT  = 8'h30;
  localparam logic [FL_DATA_W-1:0] CMD_RESET = 8'hf0;

  typedef enum logic [2:0] {
    OP_NONE   = 3'h0,
    OP_READ   = 3'h1,
    OP_PROG   = 3'h2,
    OP_CHIP   = 3'h3,
    OP_SECTOR = 3'h4,
    OP_ADDSEC = 3'h5,
    OP_RESET  = 3'h6
  } fws_op_e;

  // ==========================================================================
  // Register map (APB, byte addresses)
  // ==========================================================================
  localparam int                 APB_AW     = 8;
  localparam logic [APB_AW-1:0]  REG_CTRL   = 8'h00;
  localparam logic [APB_AW-1:0]  REG_ADDR   = 8'h04;
  localparam logic [APB_AW-1:0]  REG_WDATA  = 8'h08;
  localparam logic [APB_AW-1:0]  REG_STATUS = 8'h0c;
  localparam logic [APB_AW-1:0]  REG_RDATA  = 8'h10;

  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_FAIL    = 2;
  localparam int ST_EWIN    = 3;
  localparam int ST_DROPPED = 4;
  localparam int ST_REFUSED = 5;
  localparam int ST_RYBY    = 6;
  localparam int ST_LOCKOUT = 7;
  localparam int ST_W       = 8;

  localparam logic [ST_W-1:0] STICKY_MASK = 8'h3e;

endpackage

// File: sim/fws_flash_host_asserts.sv
// Port protocol checks for the flash host controller
`timescale 1ns/1ps
module fws_host_chk
(
  // Clock and reset
  input wire logic               CORE_CLK,
  input wire logic               NRST,
  // APB
  input wire logic               PSEL,
  input wire logic               PENABLE,
  input wire logic               PREADY,
  input wire logic               PSLVERR,
  // Flash pins
  input wire fws_pkg::fws_pins_s FL_PINS
);
  default clocking dc @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);
  // ==========================================
  // APB answer
  apb_wait_a: assert property ($rose(PSEL && PENABLE) |=> PREADY)
    else $error("ready missing after access start");
  apb_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  apb_access_a: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside access phase");
  apb_err_a: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  // ==========================================
  // Flash write and read cycles
  we_qual_a: assert property (!FL_PINS.we_n |-> !FL_PINS.ce_n && FL_PINS.oe_n)
    else $error("write strobe not qualified");
  we_setup_a: assert property ($fell(FL_PINS.we_n) |-> !$past(FL_PINS.ce_n) && !FL_PINS.dq_oe_n)
    else $error("write strobe without setup");
  we_len_a: assert property ($fell(FL_PINS.we_n) |-> !FL_PINS.we_n [*8] ##1 !FL_PINS.we_n
    ##1 !FL_PINS.we_n ##1 FL_PINS.we_n)
    else $error("write strobe width wrong");
  rd_float_a: assert property (!FL_PINS.oe_n |-> FL_PINS.dq_oe_n)
    else $error("host drives data during read");
endmodule
bind fws_flash_host fws_host_chk i_fws_host_chk (.CORE_CLK(CORE_CLK), .NRST(NRST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .FL_PINS(FL_PINS));

// File: sim/fws_flash_model.sv
// Behavioural flash device: command decode, status bits, ready/busy
`timescale 1ns/1ps
module fws_flash_model
#(
  parameter int PROG_NS  = 1000,
  parameter int EWIN_NS  = 50000,
  parameter int ERASE_NS = 3000
)
(
  // Bus pins
  input  wire logic [19:0] addr,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [7:0]  dq_in,
  output logic      [7:0]  dq_out,
  // Status and supply
  output logic             ready_busy_out,
  input  wire logic        supply_lockout_level
);
  logic [7:0] mem [256];
  logic [7:0] pd, last, pa;
  logic       busy, ers, fail, win, t1, t2, wq, rq, prot;
  int         step;
  realtime    t_end;
  // ==========================================
  // Command decode, small array only
  initial
  begin
    foreach (mem[i]) mem[i] = 8'hff;
    {busy, ers, fail, win, t1, t2, wq, rq, prot, last} = '0;
    step = 0;
  end
  task automatic wcyc(input logic [19:0] a, input logic [7:0] d);
    if (busy)
    begin
      if (ers && !win && d == 8'h30) t_end = $realtime + EWIN_NS;
      if (fail && d == 8'hf0) {busy, fail} = 2'b00;
    end
    else if (step == 3)
    begin
      {pa, pd, busy, ers, win, step} = {a[7:0], d, 3'b100, 32'd0};
      // Top sixteen words stand in for a protected sector
      prot = a[7:4] == 4'hf;
      fail = |(d & ~mem[a[7:0]]);
      t_end = $realtime + PROG_NS;
    end
    else if (step == 6 && (d == 8'h10 || d == 8'h30))
    begin
      {busy, ers, fail, win, step} = {3'b110, d == 8'h10, 32'd0};
      prot = d == 8'h30 && a[7:4] == 4'hf;
      t_end = $realtime + (win ? ERASE_NS : EWIN_NS);
    end
    else if (step == 2 && a == 20'h00555)
      step = d == 8'ha0 ? 3 : d == 8'h80 ? 4 : 0;
    else if (step == 0 || step == 4)
      step = (a == 20'h00555 && d == 8'haa) ? step + 1 : 0;
    else
      step = (a == 20'h002aa && d == 8'h55) ? step + 1 : 0;
  endtask
  always @(negedge we_n) wq = !ce_n && oe_n;
  always @(posedge we_n) if (wq && !supply_lockout_level) wcyc(addr, dq_in);
  always #5
  begin
    if (busy && !fail && $realtime >= t_end)
    begin
      if (ers && !win)
      begin
        win = 1'b1;
        t_end = $realtime + ERASE_NS;
      end
      else
      begin
        // Protected targets only show status, array left alone
        busy = 1'b0;
        if (!prot && ers) foreach (mem[i]) mem[i] = 8'hff;
        if (!prot && !ers) mem[pa] = pd;
      end
    end
  end
  // ==========================================
  // Reads; released bus shows inverse of last value
  always @(negedge oe_n) rq = !ce_n;
  always @(posedge oe_n)
  begin
    if (rq && busy) t1 = ~t1;
    if (rq && busy && ers) t2 = ~t2;
    rq = 1'b0;
  end
  always_comb
  begin
    if (ce_n || oe_n) dq_out = ~last;
    else if (busy) dq_out = {ers ? 1'b0 : ~pd[7], t1, fail, 1'b0, win, t2, 2'b00};
    else dq_out = mem[addr[7:0]];
  end
  always @(dq_out) if (!ce_n && !oe_n) last = dq_out;
  assign ready_busy_out = !busy;
endmodule

// File: sim/testbench.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
module testbench;
  logic               core_clk, nrst, psel, penable, pwrite, lock, pready, pslverr, ryby, e;
  logic [7:0]         paddr, fdq, dq;
  logic [31:0]        pwdata, prdata, r, s;
  fws_pkg::fws_pins_s pins;
  int                 mismatches, tests_run;
  assign dq = pins.dq_oe_n ? fdq : pins.dq_o;
  fws_flash_host i_fws_flash_host (.CORE_CLK(core_clk), .NRST(nrst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .FL_PINS(pins), .FL_DQ_I(dq),
    .READY_BUSY_OUT(ryby), .SUPPLY_LOCKOUT_LEVEL(lock));
  fws_flash_model #(.EWIN_NS(2000)) i_fws_flash_model (.addr(pins.addr), .ce_n(pins.ce_n),
    .oe_n(pins.oe_n), .we_n(pins.we_n), .dq_in(dq), .dq_out(fdq), .ready_busy_out(ryby),
    .supply_lockout_level(lock));
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // ==========================================
  // Tasks
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      mismatches++;
      test_done();
    end
    {r, e} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task automatic op(input logic [2:0] c);
    int n;
    apb(1'b1, fws_pkg::REG_STATUS, 32'h3e);
    apb(1'b1, fws_pkg::REG_CTRL, {29'h0, c});
    n = 0;
    do
    begin
      apb(1'b0, fws_pkg::REG_STATUS, 32'h0);
      n++;
    end
    while (!(r[0] === 1'b0 && (r[1] | r[2] | r[5]) === 1'b1) && n < 4000);
    if (r[0] !== 1'b0 || (r[1] | r[2] | r[5]) !== 1'b1)
    begin
      mismatches++;
      test_done();
    end
    s = r;
  endtask
  // ==========================================
  // Tests
  initial
  begin
    {nrst, psel, penable, pwrite, paddr, pwdata, lock, mismatches, tests_run} = '0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    apb(1'b0, fws_pkg::REG_STATUS, 32'h0);
    chk("reset status", 32'h40, r);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, {r[30:0], e});
    $display("test reset done");
    apb(1'b1, fws_pkg::REG_ADDR, 32'h12);
    apb(1'b1, fws_pkg::REG_WDATA, 32'ha5);
    op(3'h2);
    chk("program status", 32'h42, s);
    apb(1'b0, fws_pkg::REG_RDATA, 32'h0);
    chk("program data", 32'ha5, r);
    $display("test program done");
    apb(1'b1, fws_pkg::REG_WDATA, 32'h5a);
    op(3'h2);
    chk("fail status", 32'h44, s & 32'hf5);
    op(3'h1);
    apb(1'b0, fws_pkg::REG_RDATA, 32'h0);
    chk("kept data", 32'ha5, r);
    $display("test fail done");
    apb(1'b1, fws_pkg::REG_ADDR, 32'hf0);
    apb(1'b1, fws_pkg::REG_WDATA, 32'h00);
    op(3'h2);
    chk("protected status", 32'h42, s);
    apb(1'b0, fws_pkg::REG_RDATA, 32'h0);
    chk("protected data", 32'hff, r);
    $display("test protect done");
    lock <= 1'b1;
    op(3'h2);
    chk("lockout status", 32'he0, s & 32'hfd);
    lock <= 1'b0;
    $display("test lockout done");
    apb(1'b1, fws_pkg::REG_ADDR, 32'h40);
    op(3'h4);
    op(3'h5);
    chk("added sector", 32'h0, s & 32'h10);
    repeat (500) @(posedge core_clk);
    op(3'h5);
    chk("dropped sector", 32'h18, s & 32'h18);
    repeat (700) @(posedge core_clk);
    op(3'h3);
    chk("chip erase", 32'h2, s & 32'h27);
    op(3'h6);
    chk("reset op", 32'h2, s & 32'h27);
    $display("test erase done");
    test_done();
  end
endmodule
